// File: pin_change_pkg.sv
// Constants, register map and carrier types for the pin-change unit
package pin_change_pkg;

   localparam int          PORT_W      = 8;
   localparam int          NUM_PORTS   = 4;
   localparam int          ADR_W       = 8;
   localparam int          DAT_W       = 32;
   localparam int          SEL_W       = 4;

   // Port slots inside the register arrays
   localparam logic [1:0]  PORT_A      = 2'h0;
   localparam logic [1:0]  PORT_B      = 2'h1;
   localparam logic [1:0]  PORT_C      = 2'h2;
   localparam logic [1:0]  PORT_E      = 2'h3;

   // Byte addresses on the register bus
   localparam logic [7:0]  ADR_A_RISE  = 8'h00;
   localparam logic [7:0]  ADR_A_FALL  = 8'h04;
   localparam logic [7:0]  ADR_A_FLAG  = 8'h08;
   localparam logic [7:0]  ADR_B_RISE  = 8'h10;
   localparam logic [7:0]  ADR_B_FALL  = 8'h14;
   localparam logic [7:0]  ADR_B_FLAG  = 8'h18;
   localparam logic [7:0]  ADR_C_RISE  = 8'h20;
   localparam logic [7:0]  ADR_C_FALL  = 8'h24;
   localparam logic [7:0]  ADR_C_FLAG  = 8'h28;
   localparam logic [7:0]  ADR_E_RISE  = 8'h30;
   localparam logic [7:0]  ADR_E_FALL  = 8'h34;
   localparam logic [7:0]  ADR_E_FLAG  = 8'h38;
   localparam logic [7:0]  ADR_PERIPHERAL_IRQ_ENABLE_0    = 8'h40;
   localparam logic [7:0]  ADR_PERIPHERAL_IRQ_REQUEST_0    = 8'h44;

   // Field positions and reset values
   localparam int          MASTER_EN_BIT = 4;
   localparam int          SUMMARY_BIT   = 4;
   localparam int          PORT_E_PIN    = 3;
   localparam logic [7:0]  REG_RESET     = 8'h00;
   localparam logic [7:0]  FULL_MASK     = 8'hff;
   localparam logic [7:0]  PORT_E_MASK   = 8'h08;
   localparam logic [31:0] DATA_ZERO     = 32'h0000_0000;

   typedef enum logic [2:0] {
      KIND_RISE = 3'b001,
      KIND_FALL = 3'b010,
      KIND_FLAG = 3'b100
   } reg_kind_t;

   typedef struct packed {
      logic             hit;
      logic             is_peripheral_irq_enable_0;
      logic             is_peripheral_irq_request_0;
      logic [1:0]       port;
      reg_kind_t        kind;
   } reg_decode_t;

   typedef struct packed {
      logic             cyc;
      logic             stb;
      logic             we;
      logic [ADR_W-1:0] adr;
      logic [SEL_W-1:0] sel;
      logic [DAT_W-1:0] dat;
   } wb_req_t;

   typedef struct packed {
      logic [DAT_W-1:0] dat;
      logic             ack;
   } wb_rsp_t;

endpackage : pin_change_pkg

// File: edge_sense.sv
// Pin synchroniser and one-cycle rising and falling edge pulses
`timescale 1ns/10ps
module edge_sense
   import pin_change_pkg::*;
(
   input  wire logic [pin_change_pkg::PORT_W-1:0] pins,
   input  wire logic                              clk,
   input  wire logic                              srst,
   output logic      [pin_change_pkg::PORT_W-1:0] rise,
   output logic      [pin_change_pkg::PORT_W-1:0] fall
);
   import pin_change_pkg::*;

   logic [PORT_W-1:0] meta;
   logic [PORT_W-1:0] sample;
   logic [PORT_W-1:0] prev;
   logic [PORT_W-1:0] next_meta;
   logic [PORT_W-1:0] next_sample;
   logic [PORT_W-1:0] next_prev;

   always_comb begin
      next_meta   = pins;
      next_sample = meta;
      next_prev   = sample;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         meta   <= REG_RESET;
         sample <= REG_RESET;
         prev   <= REG_RESET;
      end else begin
         meta   <= next_meta;
         sample <= next_sample;
         prev   <= next_prev;
      end
   end

   // Pulses last exactly one cycle per transition
   assign rise = sample & ~prev;
   assign fall = ~sample & prev;

endmodule : edge_sense

// File: change_flags.sv
// Per-port change flags: hardware set, software write, a hardware edge wins over the write
`timescale 1ns/10ps
module change_flags
   import pin_change_pkg::*;
(
   input  wire logic                              clk,
   input  wire logic                              srst,
   input  wire logic [pin_change_pkg::PORT_W-1:0] impl_mask,
   input  wire logic [pin_change_pkg::PORT_W-1:0] rise,
   input  wire logic [pin_change_pkg::PORT_W-1:0] fall,
   input  wire logic [pin_change_pkg::PORT_W-1:0] rise_en,
   input  wire logic [pin_change_pkg::PORT_W-1:0] fall_en,
   input  wire logic                              wr,
   input  wire logic [pin_change_pkg::PORT_W-1:0] wdata,
   output logic      [pin_change_pkg::PORT_W-1:0] flags
);
   import pin_change_pkg::*;

   logic [PORT_W-1:0] hit;
   logic [PORT_W-1:0] next_flags;

   always_comb begin
      hit        = ((rise & rise_en) | (fall & fall_en)) & impl_mask;
      next_flags = flags;
      if (wr) begin
         next_flags = wdata & impl_mask;
      end
      next_flags = next_flags | hit;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         flags <= REG_RESET;
      end else begin
         flags <= next_flags;
      end
   end

endmodule : change_flags

// File: pin_change_interrupt.sv
// Pin-change interrupt unit with a classic Wishbone register slave
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
module pin_change_interrupt
   import pin_change_pkg::*;
(
   input  wire logic                              clk,
   input  wire logic                              srst,
   input  wire pin_change_pkg::wb_req_t           wb_req,
   output pin_change_pkg::wb_rsp_t                wb_rsp,
   input  wire logic [pin_change_pkg::PORT_W-1:0] port_a_a,
   input  wire logic [pin_change_pkg::PORT_W-1:0] port_b_b,
   input  wire logic [pin_change_pkg::PORT_W-1:0] port_c_c,
   input  wire logic                              port_e_pin_three,
   input  wire logic                              cpu_sleeping,
   output logic                                   change_irq_request,
   output logic                                   wake_request
);
   import pin_change_pkg::*;

   typedef enum logic [1:0] {
      BUS_IDLE   = 2'b01,
      BUS_ANSWER = 2'b10
   } bus_state_t;

   // Register map decode, shared by the read and write paths
   function automatic reg_decode_t decode(input logic [ADR_W-1:0] adr);
      reg_decode_t d;
      d         = '0;
      d.kind    = KIND_RISE;
      d.hit     = 1'b1;
      unique case (adr)
         ADR_A_RISE: begin
            d.port = PORT_A;
            d.kind = KIND_RISE;
         end
         ADR_A_FALL: begin
            d.port = PORT_A;
            d.kind = KIND_FALL;
         end
         ADR_A_FLAG: begin
            d.port = PORT_A;
            d.kind = KIND_FLAG;
         end
         ADR_B_RISE: begin
            d.port = PORT_B;
            d.kind = KIND_RISE;
         end
         ADR_B_FALL: begin
            d.port = PORT_B;
            d.kind = KIND_FALL;
         end
         ADR_B_FLAG: begin
            d.port = PORT_B;
            d.kind = KIND_FLAG;
         end
         ADR_C_RISE: begin
            d.port = PORT_C;
            d.kind = KIND_RISE;
         end
         ADR_C_FALL: begin
            d.port = PORT_C;
            d.kind = KIND_FALL;
         end
         ADR_C_FLAG: begin
            d.port = PORT_C;
            d.kind = KIND_FLAG;
         end
         ADR_E_RISE: begin
            d.port = PORT_E;
            d.kind = KIND_RISE;
         end
         ADR_E_FALL: begin
            d.port = PORT_E;
            d.kind = KIND_FALL;
         end
         ADR_E_FLAG: begin
            d.port = PORT_E;
            d.kind = KIND_FLAG;
         end
         ADR_PERIPHERAL_IRQ_ENABLE_0: begin
            d.is_peripheral_irq_enable_0 = 1'b1;
         end
         ADR_PERIPHERAL_IRQ_REQUEST_0: begin
            d.is_peripheral_irq_request_0 = 1'b1;
         end
         default: begin
            d.hit = 1'b0;
         end
      endcase
      return d;
   endfunction : decode

   // Implemented bits of each port slot
   function automatic logic [PORT_W-1:0] port_mask(input logic [1:0] p);
      return (p == PORT_E) ? PORT_E_MASK : FULL_MASK;
   endfunction : port_mask

   logic [PORT_W-1:0] rise_en     [NUM_PORTS];
   logic [PORT_W-1:0] fall_en     [NUM_PORTS];
   logic [PORT_W-1:0] next_rise_en[NUM_PORTS];
   logic [PORT_W-1:0] next_fall_en[NUM_PORTS];
   logic [PORT_W-1:0] flags       [NUM_PORTS];
   logic [PORT_W-1:0] pins        [NUM_PORTS];
   logic [PORT_W-1:0] rise        [NUM_PORTS];
   logic [PORT_W-1:0] fall        [NUM_PORTS];
   logic [NUM_PORTS-1:0] flag_wr;

   logic              master_en;
   logic              next_master_en;
   logic              summary;
   logic              next_irq;
   logic              next_wake;

   bus_state_t        bus_state;
   bus_state_t        next_bus_state;
   logic [DAT_W-1:0]  rdata;
   logic [DAT_W-1:0]  next_rdata;
   logic              wr_commit;
   logic [PORT_W-1:0] wbyte;
   reg_decode_t       dec;

   // port E carries pin three only
   always_comb begin
      pins[PORT_A]             = port_a_a;
      pins[PORT_B]             = port_b_b;
      pins[PORT_C]             = port_c_c;
      pins[PORT_E]             = REG_RESET;
      pins[PORT_E][PORT_E_PIN] = port_e_pin_three;
   end

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      edge_sense u_edge (
         .pins (pins[p]),
         .clk  (clk),
         .srst (srst),
         .rise (rise[p]),
         .fall (fall[p])
      );

      change_flags u_flags (
         .clk       (clk),
         .srst      (srst),
         .impl_mask (port_mask(2'(p))),
         .rise      (rise[p]),
         .fall      (fall[p]),
         .rise_en   (rise_en[p]),
         .fall_en   (fall_en[p]),
         .wr        (flag_wr[p]),
         .wdata     (wbyte),
         .flags     (flags[p])
      );
   end

   // Bus request decode
   always_comb begin
      dec       = decode(wb_req.adr);
      wbyte     = wb_req.dat[PORT_W-1:0];
      // Write lands at the edge where the master sees ack
      wr_commit = wb_req.cyc && wb_req.stb && wb_req.we
                  && wb_req.sel[0] && (bus_state == BUS_ANSWER);
   end

   // Flag write strobes, one per port slot
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         flag_wr[p] = wr_commit && dec.hit && (dec.kind == KIND_FLAG)
                      && !dec.is_peripheral_irq_enable_0 && !dec.is_peripheral_irq_request_0
                      && (dec.port == 2'(p));
      end
   end

   // Enable and master registers
   always_comb begin
      next_master_en = master_en;
      for (int p = 0; p < NUM_PORTS; p++) begin
         next_rise_en[p] = rise_en[p];
         next_fall_en[p] = fall_en[p];
      end
      if (wr_commit && dec.hit) begin
         if (dec.is_peripheral_irq_enable_0) begin
            next_master_en = wbyte[MASTER_EN_BIT];
         end else if (!dec.is_peripheral_irq_request_0) begin
            if (dec.kind == KIND_RISE) begin
               next_rise_en[dec.port] = wbyte & port_mask(dec.port);
            end
            if (dec.kind == KIND_FALL) begin
               next_fall_en[dec.port] = wbyte & port_mask(dec.port);
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         master_en <= 1'b0;
         for (int p = 0; p < NUM_PORTS; p++) begin
            rise_en[p] <= REG_RESET;
            fall_en[p] <= REG_RESET;
         end
      end else begin
         master_en <= next_master_en;
         for (int p = 0; p < NUM_PORTS; p++) begin
            rise_en[p] <= next_rise_en[p];
            fall_en[p] <= next_fall_en[p];
         end
      end
   end

   // Summary flag and request outputs
   always_comb begin
      summary = 1'b0;
      for (int p = 0; p < NUM_PORTS; p++) begin
         summary = summary | (|flags[p]);
      end
      next_irq  = summary && master_en;
      next_wake = summary && master_en && cpu_sleeping;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         change_irq_request <= 1'b0;
         wake_request       <= 1'b0;
      end else begin
         change_irq_request <= next_irq;
         wake_request       <= next_wake;
      end
   end

   // Bus slave: one wait state, ack for a single cycle
   always_comb begin
      next_bus_state = bus_state;
      next_rdata     = rdata;
      unique case (bus_state)
         BUS_IDLE: begin
            if (wb_req.cyc && wb_req.stb) begin
               next_bus_state = BUS_ANSWER;
               // Unmapped words answer with zero
               next_rdata     = DATA_ZERO;
               if (dec.hit && dec.is_peripheral_irq_enable_0) begin
                  next_rdata[MASTER_EN_BIT] = master_en;
               end else if (dec.hit && dec.is_peripheral_irq_request_0) begin
                  next_rdata[SUMMARY_BIT] = summary;
               end else if (dec.hit) begin
                  unique case (dec.kind)
                     KIND_RISE: next_rdata[PORT_W-1:0] = rise_en[dec.port];
                     KIND_FALL: next_rdata[PORT_W-1:0] = fall_en[dec.port];
                     KIND_FLAG: next_rdata[PORT_W-1:0] = flags[dec.port];
                  endcase
               end
            end
         end
         BUS_ANSWER: begin
            next_bus_state = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         bus_state <= BUS_IDLE;
         rdata     <= DATA_ZERO;
      end else begin
         bus_state <= next_bus_state;
         rdata     <= next_rdata;
      end
   end

   always_comb begin
      wb_rsp.dat = rdata;
      wb_rsp.ack = (bus_state == BUS_ANSWER);
   end

endmodule : pin_change_interrupt

// File: pci_chk.sv
// Port-level assertions for the pin-change unit
`timescale 1ns/10ps
module pci_chk
   import pin_change_pkg::*;
(
   input wire logic                    clk,
   input wire logic                    srst,
   input wire pin_change_pkg::wb_req_t wb_req,
   input wire pin_change_pkg::wb_rsp_t wb_rsp,
   input wire logic [7:0]              port_a_a,
   input wire logic [7:0]              port_b_b,
   input wire logic [7:0]              port_c_c,
   input wire logic                    port_e_pin_three,
   input wire logic                    cpu_sleeping,
   input wire logic                    change_irq_request,
   input wire logic                    wake_request
);
   logic [24:0] prev;
   logic [3:0]  quiet;
   logic [3:0]  next_quiet;
   logic        wr_ack;
   logic        rd_ack;

   assign wr_ack = wb_rsp.ack && wb_req.we;
   assign rd_ack = wb_rsp.ack && !wb_req.we;

   // Cycles since a pin moved or a write landed
   always_comb begin
      next_quiet = quiet + {3'h0, quiet != 4'hf};
      if (srst || wr_ack ||
          {port_a_a, port_b_b, port_c_c, port_e_pin_three} != prev) begin
         next_quiet = 4'h0;
      end
   end

   always_ff @(posedge clk) begin
      prev  <= {port_a_a, port_b_b, port_c_c, port_e_pin_three};
      quiet <= next_quiet;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_req;
      $rose(wb_req.cyc && wb_req.stb);
   endsequence
   sequence s_ack_pulse;
      wb_rsp.ack ##1 !wb_rsp.ack;
   endsequence

   a_ack_one_wait: assert property (s_req |=> s_ack_pulse)
      else $error("ack not one cycle after request");
   a_reset_quiet: assert property ($fell(srst) |->
      !wb_rsp.ack && !change_irq_request && !wake_request)
      else $error("outputs active after reset");
   a_high_bits_zero: assert property (rd_ack |->
      wb_rsp.dat[31:8] == 24'h0)
      else $error("read data above bit 7 not zero");
   a_port_e_bits: assert property (rd_ack && wb_req.adr[7:4] == 4'h3 |->
      (wb_rsp.dat[7:0] & ~PORT_E_MASK) == 8'h00)
      else $error("port E unused bit reads one");
   a_unmapped_zero: assert property (rd_ack && wb_req.adr > ADR_PERIPHERAL_IRQ_REQUEST_0 |->
      wb_rsp.dat == DATA_ZERO)
      else $error("unmapped read not zero");
   a_irq_cause: assert property ($rose(change_irq_request) |->
      quiet < 4'h6)
      else $error("request rose without pin edge or write");
   a_irq_clear: assert property ($fell(change_irq_request) |->
      $past(wr_ack, 2))
      else $error("request fell without a write");
   a_wake_gated: assert property (wake_request |->
      change_irq_request && $past(cpu_sleeping))
      else $error("wake without request or sleep");
   a_wake_follows: assert property (
      change_irq_request && $past(cpu_sleeping) |-> wake_request)
      else $error("no wake while sleeping with request");
endmodule : pci_chk

bind pin_change_interrupt pci_chk chk_u (
   .clk(clk), .srst(srst), .wb_req(wb_req), .wb_rsp(wb_rsp),
   .port_a_a(port_a_a), .port_b_b(port_b_b), .port_c_c(port_c_c),
   .port_e_pin_three(port_e_pin_three), .cpu_sleeping(cpu_sleeping),
   .change_irq_request(change_irq_request), .wake_request(wake_request)
);

// File: pin_world.sv
// Pin levels and a sleeping processor facing the pin-change unit
`timescale 1ns/10ps
module pin_world
   import pin_change_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  wake_request,
   output logic [7:0] port_a_a,
   output logic [7:0] port_b_b,
   output logic [7:0] port_c_c,
   output logic       port_e_pin_three,
   output logic       cpu_sleeping
);
   initial begin
      {port_a_a, port_b_b, port_c_c, port_e_pin_three} = 25'h0;
      cpu_sleeping = 1'b0;
   end

   // Levels move just after an edge, then hold
   task automatic drive(input logic [24:0] v);
      {port_a_a, port_b_b, port_c_c, port_e_pin_three} <= v;
   endtask : drive

   task automatic nap();
      cpu_sleeping <= 1'b1;
   endtask : nap

   always @(posedge clk) begin
      if (wake_request === 1'b1) begin
         cpu_sleeping <= 1'b0;
      end
   end
endmodule : pin_world

// File: tb_pin_change_interrupt.sv
// Self-checking bench for the pin-change unit
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
   errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_pin_change_interrupt;
   import pin_change_pkg::*;
   logic       clk;
   logic       srst;
   wb_req_t    req;
   wb_rsp_t    rsp;
   logic [7:0] pa;
   logic [7:0] pb;
   logic [7:0] pc;
   logic       pe;
   logic       slp;
   logic       irq;
   logic       wake;
   int         errors;
   int         total_checks;

   pin_change_interrupt dut_u (.clk(clk), .srst(srst), .wb_req(req),
      .wb_rsp(rsp), .port_a_a(pa), .port_b_b(pb), .port_c_c(pc),
      .port_e_pin_three(pe), .cpu_sleeping(slp),
      .change_irq_request(irq), .wake_request(wake));
   pin_world pw_u (.clk(clk), .wake_request(wake), .port_a_a(pa),
      .port_b_b(pb), .port_c_c(pc), .port_e_pin_three(pe),
      .cpu_sleeping(slp));

   task automatic complete_run();
      if (errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run

   // Request stands until ack is sampled high at a rising edge
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [31:0] q);
      int   n;
      logic seen;
      n = 0;
      req <= '{1'b1, 1'b1, w, a, 4'hf, {24'h0, d}};
      do begin
         @(posedge clk);
         n++;
      end while (rsp.ack !== 1'b1 && n < 20);
      seen = (rsp.ack === 1'b1);
      q    = rsp.dat;
      // Write landed at this edge; one idle cycle before the next request
      req <= '0;
      @(posedge clk);
      if (!seen) begin
         errors++;
         complete_run();
      end
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      `CHK($sformatf("reg %h", a), e, q)
   endtask : rd

   // Mask out only the bits seen set, so a newer edge survives
   task automatic clr(input logic [7:0] a);
      logic [31:0] seen;
      logic [31:0] now;
      bus(1'b0, a, 8'h00, seen);
      bus(1'b0, a, 8'h00, now);
      wr(a, now[7:0] & (seen[7:0] ^ FULL_MASK));
      rd(a, DATA_ZERO);
   endtask : clr

   task automatic t_reset();
      for (int a = 0; a < 'h50; a += 4) begin
         rd(8'(a), DATA_ZERO);
      end
   endtask : t_reset

   task automatic t_regs();
      logic [7:0] a;
      for (int p = 0; p < 8; p++) begin
         a = 8'(p / 2 * 16 + p % 2 * 4);
         wr(a, FULL_MASK);
         rd(a, {24'h0, (p > 5 ? PORT_E_MASK : FULL_MASK)});
         wr(a, 8'h00);
      end
      wr(ADR_PERIPHERAL_IRQ_REQUEST_0, FULL_MASK);
      wr(ADR_E_FLAG, FULL_MASK);
      rd(ADR_E_FLAG, 32'h08);
      rd(ADR_PERIPHERAL_IRQ_REQUEST_0, 32'h10);
      clr(ADR_E_FLAG);
      rd(ADR_PERIPHERAL_IRQ_REQUEST_0, DATA_ZERO);
   endtask : t_regs

   // Rise then fall on every pin; flags follow the enables
   task automatic t_edge(input logic [7:0] r, input logic [7:0] f);
      logic [7:0] e;
      logic [7:0] m;
      for (int p = 0; p < 4; p++) begin
         wr(8'(p * 16), r);
         wr(8'(p * 16 + 4), f);
      end
      for (int s = 0; s < 2; s++) begin
         e = s ? f : r;
         pw_u.drive(s ? 25'h0 : 25'h1ffffff);
         repeat (4) @(posedge clk);
         for (int p = 0; p < 4; p++) begin
            m = (p == 3) ? (e & PORT_E_MASK) : e;
            rd(8'(p * 16 + 8), {24'h0, m});
         end
         rd(ADR_PERIPHERAL_IRQ_REQUEST_0, e != 8'h00 ? 32'h10 : DATA_ZERO);
         @(negedge clk);
         `CHK("irq", 1'b0, irq)
         @(posedge clk);
         for (int p = 0; p < 4; p++) begin
            clr(8'(p * 16 + 8));
         end
      end
   endtask : t_edge

   task automatic t_race();
      wr(ADR_A_RISE, 8'h03);
      wr(ADR_A_FALL, 8'h00);
      pw_u.drive(25'h0040000);
      repeat (4) @(posedge clk);
      rd(ADR_A_FLAG, 32'h02);
      pw_u.drive(25'h0060000);
      @(posedge clk);
      // Edge pulse lands in the cycle the clearing write takes effect
      wr(ADR_A_FLAG, 8'h00);
      rd(ADR_A_FLAG, 32'h01);
      wr(ADR_PERIPHERAL_IRQ_ENABLE_0, 8'h10);
      @(negedge clk);
      `CHK("irq", 1'b1, irq)
      @(posedge clk);
      clr(ADR_A_FLAG);
      @(negedge clk);
      `CHK("irq", 1'b0, irq)
      @(posedge clk);
      pw_u.drive(25'h0);
      wr(ADR_PERIPHERAL_IRQ_ENABLE_0, 8'h00);
   endtask : t_race

   task automatic t_sleep();
      int n;
      wr(ADR_B_RISE, 8'h00);
      wr(ADR_B_FALL, 8'h80);
      wr(ADR_PERIPHERAL_IRQ_ENABLE_0, 8'h10);
      pw_u.drive(25'h0010000);
      pw_u.nap();
      repeat (4) @(posedge clk);
      pw_u.drive(25'h0);
      n = 0;
      while (wake !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      `CHK("wake", 1'b1, wake)
      if (wake !== 1'b1) begin
         complete_run();
      end
      @(posedge clk);
      rd(ADR_B_FLAG, 32'h80);
      clr(ADR_B_FLAG);
      wr(ADR_PERIPHERAL_IRQ_ENABLE_0, 8'h00);
   endtask : t_sleep

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial begin
      srst <= 1'b1;
      req  <= '0;
      errors = 0;
      total_checks = 0;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_regs();
      t_edge(8'h5a, 8'h00);
      t_edge(8'h00, 8'hc3);
      t_edge(8'hff, 8'hff);
      t_race();
      t_sleep();
      complete_run();
   end
endmodule : tb_pin_change_interrupt
